// >>> sdpc_ctrl.sv
// clock, loop reset, lock, impedance and burst control
`timescale 1ns/1ps
`include "sdpc_map.svh"
module sdpc_ctrl
    import sdpc_pkg::*;
#(
    parameter int LOCK_CYCLES = `SDPC_LOCK_CYCLES,
    parameter int IMP_CYCLES = `SDPC_IMP_SETTLE_CYCLES,
    parameter int AW = `SDPC_ADDR_WIDTH
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inClkActive,
    input wire logic loopEnable,
    input wire logic outClkHigh,
    input wire logic readReq_n,
    input wire logic writeReq_n,
    input wire logic [AW-1:0] readAddr,
    input wire logic [AW-1:0] writeAddr,
    input wire logic [`SDPC_IMP_WIDTH-1:0] impTarget,
    output logic [`SDPC_IMP_WIDTH-1:0] impCode,
    output logic impDone,
    output sdpc_stat_s status,
    output logic readStrobe,
    output logic [AW-1:0] readBurstAddr,
    output logic readBeat,
    output logic [1:0] readLatency,
    output logic writeStrobe,
    output logic [AW-1:0] writeBurstAddr,
    output logic readBusy,
    output logic writeBusy
);
    // elaboration check: counters and burst field need at least two steps
    if (LOCK_CYCLES < 2 || IMP_CYCLES < 2 || AW < 2)
    begin : g_paramCheck
        $error("sdpc_ctrl: parameter out of range");
    end

    localparam int LW = $clog2(LOCK_CYCLES + 1);
    localparam int IW = $clog2(IMP_CYCLES + 1);
    localparam int SW = 4;

    // linear two-bit burst increment of the low address bits
    function automatic logic [AW-1:0] burstNext(input logic [AW-1:0] a);
        burstNext = {a[AW-1:2], 2'(a[1:0] + 2'h1)};
    endfunction : burstNext

    // three-stage synchronisers on pin inputs
    logic [2:0] clkSync, enSync, ochSync;
    logic [2:0] next_clkSync, next_enSync, next_ochSync;
    logic clkAct, enLvl, ochLvl, enPrev;
    logic next_clkAct, next_enLvl, next_ochLvl, next_enPrev;

    always_comb
    begin
        next_clkSync = {clkSync[1:0], inClkActive};
        next_enSync = {enSync[1:0], loopEnable};
        next_ochSync = {ochSync[1:0], outClkHigh};
        next_clkAct = (clkSync[1] == clkSync[2]) ? clkSync[2] : clkAct;
        next_enLvl = (enSync[1] == enSync[2]) ? enSync[2] : enLvl;
        next_ochLvl = (ochSync[1] == ochSync[2]) ? ochSync[2] : ochLvl;
        next_enPrev = enLvl;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clkSync <= 3'h0;
            enSync <= 3'h0;
            ochSync <= 3'h7;
            clkAct <= 1'b0;
            enLvl <= 1'b0;
            ochLvl <= 1'b1;
            enPrev <= 1'b0;
        end
        else
        begin
            clkSync <= next_clkSync;
            enSync <= next_enSync;
            ochSync <= next_ochSync;
            clkAct <= next_clkAct;
            enLvl <= next_enLvl;
            ochLvl <= next_ochLvl;
            enPrev <= next_enPrev;
        end
    end

    // loop reset detection, lock counter and ready
    logic [SW-1:0] stopCnt, next_stopCnt;
    logic [LW-1:0] lockCnt, next_lockCnt;
    logic locked, next_locked;
    logic loopReset;

    always_comb
    begin
        next_stopCnt = stopCnt;
        if (clkAct)
        begin
            next_stopCnt = '0;
        end
        else if (stopCnt < SW'(`SDPC_STOP_CYCLES))
        begin
            next_stopCnt = SW'(stopCnt + 1'b1);
        end
        // rising disable input or long clock stop restarts the loop
        loopReset = (enLvl && !enPrev) || (stopCnt >= SW'(`SDPC_STOP_CYCLES)); // RL7
        next_lockCnt = lockCnt;
        next_locked = locked;
        if (loopReset)
        begin
            next_lockCnt = '0;
            next_locked = 1'b0;
        end
        else if (clkAct && !locked)
        begin
            // count stable clocks; with loop bypassed same wait applies
            if (lockCnt == LW'(LOCK_CYCLES - 1)) // RL9 RL11
            begin
                next_locked = 1'b1; // RL10 RL18
            end
            next_lockCnt = LW'(lockCnt + 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stopCnt <= '0;
            lockCnt <= '0;
            locked <= 1'b0;
        end
        else
        begin
            stopCnt <= next_stopCnt;
            lockCnt <= next_lockCnt;
            locked <= next_locked;
        end
    end

    // impedance: start mid-range, step toward target, settle in time
    logic [`SDPC_IMP_WIDTH-1:0] next_impCode;
    logic [IW-1:0] impCnt, next_impCnt;
    logic next_impDone;

    always_comb
    begin
        next_impCode = impCode;
        next_impCnt = impCnt;
        next_impDone = impDone;
        if (clkAct && !impDone)
        begin
            if (impCode < impTarget)
            begin
                next_impCode = impCode + 1'b1;
            end
            else if (impCode > impTarget)
            begin
                next_impCode = impCode - 1'b1;
            end
            next_impCnt = IW'(impCnt + 1'b1);
            if (impCnt == IW'(IMP_CYCLES - 1))
            begin
                next_impCode = impTarget; // RL1
                next_impDone = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            impCode <= `SDPC_IMP_MID; // RL1
            impCnt <= '0;
            impDone <= 1'b0;
        end
        else
        begin
            impCode <= next_impCode;
            impCnt <= next_impCnt;
            impDone <= next_impDone;
        end
    end

    // status and read latency selection
    sdpc_stat_s next_status;
    logic [1:0] next_readLatency;

    always_comb
    begin
        next_status.dllOn = enLvl; // RL5 RL6
        next_status.singleClk = ochLvl; // RL2
        next_status.locked = next_locked && enLvl; // RL5
        next_status.ready = next_locked; // RL18
        // bypassed loop gives one-cycle latency, enabled loop two; single-clock mode does not change it
        next_readLatency = enLvl ? `SDPC_LAT_DLL_ON : `SDPC_LAT_DLL_OFF; // RL6 RL17
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status <= '0;
            readLatency <= `SDPC_LAT_DLL_OFF;
        end
        else
        begin
            status <= next_status;
            readLatency <= next_readLatency;
        end
    end

    // independent read and write burst machines
    sdpc_port_e rdState, next_rdState, wrState, next_wrState;
    logic [AW-1:0] next_readBurstAddr, next_writeBurstAddr;
    logic next_readStrobe, next_readBeat, next_writeStrobe;
    logic next_readBusy, next_writeBusy;

    always_comb
    begin
        next_rdState = rdState;
        next_readBurstAddr = readBurstAddr;
        next_readStrobe = 1'b0;
        next_readBeat = 1'b0;
        case (rdState) // RL16
            SDPC_IDLE, SDPC_BEAT1:
            begin
                // a request taken only once ready; low means active
                if (!readReq_n && locked) // RL15 RL10
                begin
                    next_rdState = SDPC_BEAT0;
                    next_readBurstAddr = readAddr;
                    next_readStrobe = 1'b1;
                end
                else
                begin
                    next_rdState = SDPC_IDLE;
                end
            end
            SDPC_BEAT0:
            begin
                // second beat always completes before port goes idle
                next_rdState = SDPC_BEAT1; // RL4
                next_readBurstAddr = burstNext(readBurstAddr); // RL14
                next_readStrobe = 1'b1;
                next_readBeat = 1'b1;
            end
            default:
            begin
                next_rdState = SDPC_IDLE;
            end
        endcase
        next_wrState = wrState;
        next_writeBurstAddr = writeBurstAddr;
        next_writeStrobe = 1'b0;
        case (wrState) // RL16
            SDPC_IDLE, SDPC_BEAT1:
            begin
                if (!writeReq_n && locked) // RL15 RL10
                begin
                    next_wrState = SDPC_BEAT0;
                    next_writeBurstAddr = writeAddr;
                    next_writeStrobe = 1'b1;
                end
                else
                begin
                    next_wrState = SDPC_IDLE;
                end
            end
            SDPC_BEAT0:
            begin
                next_wrState = SDPC_BEAT1; // RL4
                next_writeBurstAddr = burstNext(writeBurstAddr); // RL14
                next_writeStrobe = 1'b1;
            end
            default:
            begin
                next_wrState = SDPC_IDLE;
            end
        endcase
        next_readBusy = (next_rdState == SDPC_BEAT0);
        next_writeBusy = (next_wrState == SDPC_BEAT0);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdState <= SDPC_IDLE;
            wrState <= SDPC_IDLE;
            readBurstAddr <= '0;
            writeBurstAddr <= '0;
            readStrobe <= 1'b0;
            readBeat <= 1'b0;
            writeStrobe <= 1'b0;
            readBusy <= 1'b0;
            writeBusy <= 1'b0;
        end
        else
        begin
            rdState <= next_rdState;
            wrState <= next_wrState;
            readBurstAddr <= next_readBurstAddr;
            writeBurstAddr <= next_writeBurstAddr;
            readStrobe <= next_readStrobe;
            readBeat <= next_readBeat;
            writeStrobe <= next_writeStrobe;
            readBusy <= next_readBusy;
            writeBusy <= next_writeBusy;
        end
    end
endmodule : sdpc_ctrl

// >>> sdpc_ctrl_model.sv
// memory controller pin driver for the sdpc bench
`timescale 1ns/1ps
module sdpc_ctrl_model (
    input wire logic clk,
    input wire logic stopReq,
    input wire logic bypassReq,
    input wire logic singleReq,
    output logic inClkActive,
    output logic loopEnable,
    output logic outClkHigh
);
    // pins start at definite levels, loop pin high gives the power-up reset
    initial {inClkActive, loopEnable, outClkHigh} = 3'b110;
    // clock pair stops only on request, disable rises re-lock the loop
    always @(posedge clk)
    begin
        inClkActive <= !stopReq;
        loopEnable <= !bypassReq;
        outClkHigh <= singleReq;
    end
endmodule : sdpc_ctrl_model

// >>> sdpc_ctrl_properties.sv
// port assertions for the sdpc control block
`timescale 1ns/1ps
`include "sdpc_map.svh"
module sdpc_ctrl_properties
    import sdpc_pkg::*;
#(
    parameter int LOCK_CYCLES = 16,
    parameter int IMP_CYCLES = 8,
    parameter int AW = 20
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic loopEnable,
    input wire logic [`SDPC_IMP_WIDTH-1:0] impTarget,
    input wire logic [`SDPC_IMP_WIDTH-1:0] impCode,
    input wire logic impDone,
    input wire sdpc_stat_s status,
    input wire logic readStrobe,
    input wire logic [AW-1:0] readBurstAddr,
    input wire logic readBeat,
    input wire logic [1:0] readLatency,
    input wire logic writeStrobe,
    input wire logic [AW-1:0] writeBurstAddr,
    input wire logic readBusy,
    input wire logic writeBusy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // cycles spent not ready, saturating at the lock count
    int waitCnt;
    int next_waitCnt;
    always_comb next_waitCnt = status.ready ? 0 : ((waitCnt < LOCK_CYCLES) ? waitCnt + 1 : waitCnt);
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) waitCnt <= 0;
        else waitCnt <= next_waitCnt;
    // checks on impedance, lock, bursts and mode
    a_imp_start: assert property ($rose(rst_n) |-> impCode == `SDPC_IMP_MID) else $error("impedance not mid");
    a_imp_final: assert property ($rose(impDone) |-> impCode == impTarget) else $error("impedance not settled");
    a_lock_wait: assert property ($rose(status.ready) |-> waitCnt == LOCK_CYCLES) else $error("ready early");
    a_loop_reset: assert property ($rose(loopEnable) |-> ##[1:6] !status.ready) else $error("no loop reset");
    a_refuse_idle: assert property (!status.ready && !readBusy |=> !readStrobe) else $error("read while unready");
    a_refuse_write: assert property (!status.ready && !writeBusy |=> !writeStrobe) else $error("write unready");
    a_locked_mode: assert property (status.locked == (status.ready && status.dllOn)) else $error("lock flag wrong");
    a_bypass_lat: assert property ($stable(status.dllOn) |-> readLatency == (status.dllOn ? `SDPC_LAT_DLL_ON
        : `SDPC_LAT_DLL_OFF)) else $error("latency wrong");
    a_read_busy: assert property (readStrobe |-> readBusy == !readBeat) else $error("busy mismatch");
    a_read_pair: assert property (readStrobe && !readBeat |=> readStrobe && readBeat &&
        $stable(readBurstAddr[AW-1:2]) && readBurstAddr[1:0] == $past(readBurstAddr[1:0]) + 2'h1)
        else $error("read burst wrong");
    a_write_pair: assert property (writeStrobe && writeBusy |=> writeStrobe && !writeBusy
        && writeBurstAddr[1:0] == $past(writeBurstAddr[1:0]) + 2'h1) else $error("write burst wrong");
    c_ready: cover property ($rose(status.ready));
endmodule : sdpc_ctrl_properties
bind sdpc_ctrl sdpc_ctrl_properties #(.LOCK_CYCLES(LOCK_CYCLES), .IMP_CYCLES(IMP_CYCLES), .AW(AW))
    i_sdpc_ctrl_properties (.clk(clk), .rst_n(rst_n), .loopEnable(loopEnable), .impTarget(impTarget),
    .impCode(impCode), .impDone(impDone), .status(status), .readStrobe(readStrobe), .readBurstAddr(readBurstAddr),
    .readBeat(readBeat), .readLatency(readLatency), .writeStrobe(writeStrobe), .writeBurstAddr(writeBurstAddr),
    .readBusy(readBusy), .writeBusy(writeBusy));

// >>> sdpc_map.svh
// constants for the sram dll power-up control block
// Function
// RL1: driver impedance starts mid, settles within 1024 clocks
// RL2: output clocks held high select single-clock mode
// RL3: controller toggles both polarities of used clock pair
// RL4: ports deselect only after pending transactions finish
// RL5: enabled loop keeps tracking input clock
// RL6: disable low bypasses loop, one-cycle read latency
// RL7: disable rise or 30ns clock stop resets loop
// RL8: controller resets loop at power-up and frequency change
// RL9: loop locks after 2048 stable input clocks
// RL10: normal operation only after lock period ends
// RL11: disable low skips locking, still waits lock period
// RL12: early disable rise needs controller loop reset
// RL13: controller keeps all inputs at definite levels
// RL14: two-bit linear burst, second address first plus one
// RL15: request low means active, high means inactive
// RL16: read and write machines run independently on clock
// RL17: single-clock reads launch at 1.5 and 2 cycles; code sets latency 2 or 1 from loop enable only
// RL18: ready asserts only after lock counter expires
`ifndef SDPC_MAP_SVH
`define SDPC_MAP_SVH
`define SDPC_IMP_SETTLE_CYCLES 1024
`define SDPC_LOCK_CYCLES 2048
`define SDPC_STOP_TIME_NS 30
`define SDPC_CLK_PERIOD_NS 5
`define SDPC_STOP_CYCLES ((`SDPC_STOP_TIME_NS + `SDPC_CLK_PERIOD_NS - 1) / `SDPC_CLK_PERIOD_NS)
`define SDPC_IMP_WIDTH 6
`define SDPC_IMP_MID 6'h20
`define SDPC_ADDR_WIDTH 20
`define SDPC_LAT_DLL_ON 2'h2
`define SDPC_LAT_DLL_OFF 2'h1
`endif

// >>> sdpc_pkg.sv
// types for the sram dll power-up control block
package sdpc_pkg;
    typedef enum logic [1:0] {
        SDPC_IDLE = 2'b00,
        SDPC_BEAT0 = 2'b01,
        SDPC_BEAT1 = 2'b10
    } sdpc_port_e;
    typedef struct packed {
        logic dllOn;
        logic singleClk;
        logic ready;
        logic locked;
    } sdpc_stat_s;
endpackage : sdpc_pkg

// >>> sram_dll_powerup_control_tb.sv
// self-checking bench for the sdpc control block
`timescale 1ns/1ps
module sram_dll_powerup_control_tb;
    import sdpc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, stopReq = 1'b0, bypassReq = 1'b0, singleReq = 1'b0;
    logic readReq_n = 1'b1, writeReq_n = 1'b1, inClkActive, loopEnable, outClkHigh;
    logic [19:0] readAddr = 20'h00000, writeAddr = 20'h00000, readBurstAddr, writeBurstAddr, rdQ[$], wrQ[$];
    logic [5:0] impTarget = 6'h00, impCode;
    logic impDone, readStrobe, readBeat, writeStrobe, readBusy, writeBusy;
    logic [1:0] readLatency;
    sdpc_stat_s status;
    logic [31:0] seed = 32'h52b6d810;
    int num_errors = 0, cmp_count = 0, cycles = 0;
    sdpc_ctrl_model i_sdpc_ctrl_model (.clk(clk), .stopReq(stopReq), .bypassReq(bypassReq),
        .singleReq(singleReq), .inClkActive(inClkActive), .loopEnable(loopEnable), .outClkHigh(outClkHigh));
    sdpc_ctrl #(.LOCK_CYCLES(16), .IMP_CYCLES(8), .AW(20)) i_sdpc_ctrl (.clk(clk), .rst_n(rst_n),
        .inClkActive(inClkActive), .loopEnable(loopEnable), .outClkHigh(outClkHigh), .readReq_n(readReq_n),
        .writeReq_n(writeReq_n), .readAddr(readAddr), .writeAddr(writeAddr), .impTarget(impTarget),
        .impCode(impCode), .impDone(impDone), .status(status), .readStrobe(readStrobe),
        .readBurstAddr(readBurstAddr), .readBeat(readBeat), .readLatency(readLatency), .writeStrobe(writeStrobe),
        .writeBurstAddr(writeBurstAddr), .readBusy(readBusy), .writeBusy(writeBusy));
    initial forever #2.5 clk = !clk;
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsrNext
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    task automatic waitReady(input logic lvl);
        for (int n = 0; n < 300 && status.ready !== lvl; n++) @(negedge clk);
        check(status.ready, lvl);
    endtask : waitReady
    // one request per port, expected beats noted when it should be taken
    task automatic burst(input logic r, input logic w, input logic ok);
        seed = lfsrNext(seed);
        @(posedge clk);
        readReq_n <= !r;
        writeReq_n <= !w;
        readAddr <= seed[19:0];
        writeAddr <= {seed[31:14], 2'b11};
        if (r && ok) rdQ.push_back(seed[19:0]);
        if (r && ok) rdQ.push_back({seed[19:2], seed[1:0] + 2'h1});
        if (w && ok) wrQ.push_back({seed[31:14], 2'b11});
        if (w && ok) wrQ.push_back({seed[31:14], 2'b00});
        @(posedge clk);
        readReq_n <= 1'b1;
        writeReq_n <= 1'b1;
    endtask : burst
    // beat monitor against the noted addresses
    always @(negedge clk)
    begin
        if (readStrobe !== 1'b0) check(readBurstAddr, rdQ.size() > 0 ? {12'h000, rdQ.pop_front()} : '1);
        if (writeStrobe !== 1'b0) check(writeBurstAddr, wrQ.size() > 0 ? {12'h000, wrQ.pop_front()} : '1);
    end
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            num_errors++;
            results();
        end
    end
    // main sequence
    initial
    begin
        @(posedge clk);
        impTarget <= seed[5:0];
        repeat (15) @(posedge clk);
        rst_n <= 1'b1;
        waitReady(1'b1);
        check(impDone, 1'b1);
        check(impCode, impTarget);
        check(status, 4'hb);
        check(readLatency, 2'h2);
        $display("test powerup done");
        for (int i = 0; i < 9; i++) burst(i % 3 != 2, i % 3 != 1, 1'b1);
        repeat (4) @(negedge clk);
        check(rdQ.size() + wrQ.size(), 0);
        $display("test bursts done");
        stopReq <= 1'b1;
        repeat (3) @(posedge clk);
        stopReq <= 1'b0;
        repeat (10) @(negedge clk);
        check(status.ready, 1'b1);
        stopReq <= 1'b1;
        waitReady(1'b0);
        stopReq <= 1'b0;
        burst(1'b1, 1'b1, 1'b0);
        waitReady(1'b1);
        $display("test clock stop done");
        bypassReq <= 1'b1;
        repeat (8) @(negedge clk);
        check(status, 4'h2);
        check(readLatency, 2'h1);
        burst(1'b1, 1'b0, 1'b1);
        bypassReq <= 1'b0;
        waitReady(1'b0);
        waitReady(1'b1);
        check(status, 4'hb);
        $display("test loop toggle done");
        singleReq <= 1'b1;
        bypassReq <= 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        waitReady(1'b1);
        check(status, 4'h6);
        check(readLatency, 2'h1);
        burst(1'b1, 1'b1, 1'b1);
        repeat (4) @(negedge clk);
        check(rdQ.size() + wrQ.size(), 0);
        $display("test single clock done");
        results();
    end
endmodule : sram_dll_powerup_control_tb
